// [logic/beat_fifo.sv]
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Synchronous active-low reset, depth a power of two
// Notes: Full and empty come straight from the occupancy count
`default_nettype none

module beat_fifo #(
	parameter int WIDTH = 51,
	parameter int DEPTH = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0] count_reg;
	wire logic push;
	wire logic pop;
	wire logic full;
	wire logic empty;

	// Occupancy flags and handshakes
	assign full = (count_reg == (PTR_W+1)'(DEPTH));
	assign empty = (count_reg == '0);
	assign push = i_in_valid && !full;
	assign pop = !empty && i_out_ready;
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = store_reg[rd_ptr_reg];

	// Pointers and count
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + {{PTR_W{1'b0}}, push}
				- {{PTR_W{1'b0}}, pop};
		end
	end

	// Storage written on push
	always_ff @(posedge i_ref_clk) begin
		if (push)
			store_reg[wr_ptr_reg] <= i_in_data;
	end
endmodule : beat_fifo

`default_nettype wire

// [logic/bus_match_counter.sv]
// Purpose: Right-port width matching with burst address counter
// Assumes: Pins synchronous to i_ref_clk, configuration held static
// Notes: Writes assemble into full words queued toward the array
`default_nettype none

module bus_match_counter
	import bus_match_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Configuration pins
	input wire logic i_width_match_select,
	input wire logic i_size_select,
	input wire logic i_endian_order_select,
	// Counter control pins
	input wire logic i_address_load_strobe_n,
	input wire logic i_count_advance_n,
	input wire logic i_counter_clear_n,
	input wire logic [ADDR_W-1:0] i_addr,
	// Access control
	input wire logic i_chip_enable_n,
	input wire logic i_write_n,
	input wire logic i_output_enable_n,
	// Right data pins as three signals
	input wire logic [WORD_W-1:0] i_data,
	output logic [WORD_W-1:0] o_data,
	output logic [WORD_W-1:0] o_data_oe,
	// Read word supplied by the array for the current address
	input wire logic [WORD_W-1:0] i_array_rdata,
	// Assembled write words toward the array
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output word_beat_t o_wr_beat,
	output logic o_accept_ready,
	// Status
	output logic [ADDR_W-1:0] o_word_addr,
	output logic [SUB_W-1:0] o_lane_index
);
	// ****************************************
	// Configuration decode
	// ****************************************
	width_mode_t width_mode;
	wire logic big_endian;
	wire logic narrow;
	wire logic [SUB_W-1:0] lane_first;
	wire logic [SUB_W-1:0] lane_final;
	wire logic [SUB_W-1:0] sub_step;

	// Width from the two select pins
	assign width_mode = !i_width_match_select ? WIDTH_36 :
		(i_size_select ? WIDTH_9 : WIDTH_18);
	// Endian ignored in the full-width mode
	assign big_endian = (width_mode != WIDTH_36)
		&& i_endian_order_select;
	assign narrow = (width_mode != WIDTH_36);
	// Halves step by two lanes, bytes by one
	assign sub_step = (width_mode == WIDTH_18) ? 2'h2 : 2'h1;
	assign lane_first = big_endian ? SUB_LAST : SUB_RESET;
	assign lane_final = big_endian ? SUB_RESET : SUB_LAST;

	// ****************************************
	// Counter command decode
	// ****************************************
	counter_cmd_t cmd;
	wire logic readback_req;

	// Clear wins, then strobe pair picks the mode; chip enable unused
	assign cmd = !i_counter_clear_n ? CMD_CLEAR :
		(!i_address_load_strobe_n && !i_count_advance_n) ? CMD_LOAD :
		(!i_count_advance_n) ? CMD_INC : CMD_HOLD;
	// Hold with strobe low, write high and output enable low is the readback mode; chip enable not decoded
	assign readback_req = i_counter_clear_n && !i_address_load_strobe_n
		&& i_count_advance_n && i_write_n && !i_output_enable_n;

	// ****************************************
	// Address and lane sub-counter
	// ****************************************
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [SUB_W-1:0] sub_reg;
	logic [SUB_W-1:0] sub_next;
	wire logic word_done;

	assign word_done = !narrow || (sub_reg == lane_final)
		|| (width_mode == WIDTH_18 && sub_reg == (lane_final ^ 2'h1));

	// Next address and lane
	always_comb begin
		addr_next = addr_reg;
		sub_next = sub_reg;
		case (cmd)
			CMD_CLEAR: begin
				addr_next = ADDR_RESET;
				sub_next = lane_first;
			end
			CMD_LOAD: begin
				addr_next = i_addr;
				sub_next = lane_first;
			end
			CMD_INC: begin
				// Lane walks first, word advances at its end
				if (word_done) begin
					addr_next = addr_reg + 1'b1;
					sub_next = lane_first;
				end else if (big_endian)
					sub_next = sub_reg - sub_step;
				else
					sub_next = sub_reg + sub_step;
			end
			CMD_HOLD: begin
				addr_next = addr_reg;
				sub_next = sub_reg;
			end
			default: begin
				addr_next = addr_reg;
				sub_next = sub_reg;
			end
		endcase
	end

	// Counter registers, zero after reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			addr_reg <= ADDR_RESET;
			sub_reg <= SUB_RESET;
		end else begin
			addr_reg <= addr_next;
			sub_reg <= sub_next;
		end
	end

	// Lane index used on this cycle, current word address
	wire logic [SUB_W-1:0] lane_now;
	assign lane_now = (cmd == CMD_LOAD || cmd == CMD_CLEAR)
		? lane_first : sub_reg;
	wire logic [SUB_W-1:0] half_base;
	assign half_base = {lane_now[1], 1'b0};
	assign o_word_addr = addr_reg;
	assign o_lane_index = sub_reg;

	// ****************************************
	// Readback sequencer
	// ****************************************
	readback_state_t rb_state_reg;
	readback_state_t rb_state_next;

	// Byte mode needs a second readback cycle
	always_comb begin
		case (rb_state_reg)
			RB_FIRST:
				rb_state_next = (readback_req && width_mode == WIDTH_9)
					? RB_SECOND : RB_FIRST;
			RB_SECOND:
				rb_state_next = RB_FIRST;
			default:
				rb_state_next = RB_FIRST;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			rb_state_reg <= RB_FIRST;
		else
			rb_state_reg <= rb_state_next;
	end

	// ****************************************
	// Read data steering
	// ****************************************
	wire logic [LANE_W-1:0] lane_data [LANES];
	wire logic [HALF_W-1:0] half_data;
	logic [WORD_W-1:0] rd_mux;
	logic [WORD_W-1:0] width_oe;
	wire logic drive_en;

	// Four nine-bit lanes of the array word
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_data[g] = i_array_rdata[g*LANE_W +: LANE_W];
		end
	endgenerate
	assign half_data = {lane_data[half_base + 2'h1], lane_data[half_base]};

	// Data or counter value placed by width
	always_comb begin
		rd_mux = '0;
		width_oe = '0;
		case (width_mode)
			WIDTH_36: begin
				width_oe = '1;
				if (readback_req)
					rd_mux[RB36_LSB +: ADDR_W] = addr_reg;
				else
					rd_mux = i_array_rdata;
			end
			WIDTH_18: begin
				width_oe[HALF_W-1:0] = '1;
				if (readback_req)
					rd_mux[RB18_LSB +: ADDR_W+1] =
						{addr_reg, sub_reg[1]};
				else
					rd_mux[HALF_W-1:0] = half_data;
			end
			WIDTH_9: begin
				width_oe[LANE_W-1:0] = '1;
				if (rb_state_reg == RB_SECOND)
					rd_mux[RB9_LSB +: 8] =
						{addr_reg[5:0], sub_reg};
				else if (readback_req)
					rd_mux[LANE_W-1:0] = addr_reg[ADDR_W-1:6];
				else
					rd_mux[LANE_W-1:0] = lane_data[lane_now];
			end
			default: begin
				rd_mux = '0;
				width_oe = '0;
			end
		endcase
	end

	// Drive on a selected read with outputs enabled, or in the second byte readback cycle
	assign drive_en = (!i_chip_enable_n && i_write_n && !i_output_enable_n)
		|| rb_state_reg == RB_SECOND;

	// Output data from flip-flops, enable follows
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_data <= '0;
			o_data_oe <= '0;
		end else begin
			o_data <= rd_mux;
			o_data_oe <= drive_en ? width_oe : '0;
		end
	end

	// ****************************************
	// Write assembly
	// ****************************************
	logic [WORD_W-1:0] asm_reg;
	logic [WORD_W-1:0] asm_next;
	wire logic wr_cycle;
	wire logic fifo_in_ready;
	wire logic push;
	word_beat_t push_beat;

	assign wr_cycle = !i_chip_enable_n && !i_write_n;

	// Merge the incoming slice into its lanes
	always_comb begin
		asm_next = asm_reg;
		case (width_mode)
			WIDTH_36:
				asm_next = i_data;
			WIDTH_18:
				asm_next[half_base*LANE_W +: HALF_W] =
					i_data[HALF_W-1:0];
			WIDTH_9:
				asm_next[lane_now*LANE_W +: LANE_W] =
					i_data[LANE_W-1:0];
			default:
				asm_next = asm_reg;
		endcase
	end

	// Word complete on its last slice, or every 36-bit write
	assign push = wr_cycle && (!narrow
		|| lane_now == lane_final
		|| (width_mode == WIDTH_18
			&& lane_now == (lane_final ^ 2'h1)));
	assign push_beat.addr = (cmd == CMD_LOAD) ? i_addr
		: (cmd == CMD_CLEAR) ? ADDR_RESET : addr_reg;
	assign push_beat.data = asm_next;
	assign o_accept_ready = fifo_in_ready;

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n)
			asm_reg <= '0;
		else if (wr_cycle)
			asm_reg <= asm_next;
	end

	// Queue of complete words; the master watches accept ready
	beat_fifo #(
		.WIDTH($bits(word_beat_t)),
		.DEPTH(FIFO_WORDS)
	) u_wr_fifo (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_beat),
		.o_out_valid(o_wr_valid),
		.i_out_ready(i_wr_ready),
		.o_out_data(o_wr_beat)
	);
endmodule : bus_match_counter

`default_nettype wire

// [logic/bus_match_pkg.sv]
// Purpose: Constants and carrier types for the right-port width matcher
// Assumes: Single clock, synchronous active-low reset
// Notes: Shared by the counter/matcher core, the array model, the assertions and the bench
// Behaviour
// - Both selects low gives full 36-bit port
// - Match high, size low: 18 bits, pins 0-17
// - Match high, size high: 9 bits, pins 0-8
// - Endian select ignored in 36-bit mode
// - 18-bit: low half first unless big endian
// - 9-bit: lanes ascend, or descend when big endian
// - 18-bit word needs at least two cycles
// - 9-bit word needs at least four cycles
// - Sub-counter counts up little, down big
// - Two sub-counter bits extend right address
// - Word address is fifteen bits wide
// - Strobe and count-advance together load address
// - Count-advance alone increments every edge
// - Counter clear resets burst counter
// - 36-bit readback: address on pins 3-17
// - 18-bit readback one cycle; 9-bit two cycles
// - 36-bit right port without lane selects
// - Data organised as four nine-bit lanes
// - Clear first; load, hold, increment by strobes
// - Counter independent of chip enable
`default_nettype none

package bus_match_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int WORD_W = 36;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int HALF_W = 18;
	localparam int ADDR_W = 15;
	localparam int SUB_W = 2;
	localparam int FIFO_DEPTH = 4;

	// ****************************************
	// Readback pin positions and reset values
	// ****************************************
	localparam int RB36_LSB = 3;
	localparam int RB18_LSB = 2;
	localparam int RB9_LSB = 1;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
	localparam logic [SUB_W-1:0] SUB_RESET = 2'h0;
	localparam logic [SUB_W-1:0] SUB_LAST = 2'h3;

	// Port width configuration
	typedef enum logic [2:0] {
		WIDTH_36 = 3'h1,
		WIDTH_18 = 3'h2,
		WIDTH_9 = 3'h4
	} width_mode_t;

	// Counter command derived from the strobes
	typedef enum logic [3:0] {
		CMD_CLEAR = 4'h1,
		CMD_LOAD = 4'h2,
		CMD_HOLD = 4'h4,
		CMD_INC = 4'h8
	} counter_cmd_t;

	// Readback sequencing states
	typedef enum logic [1:0] {
		RB_FIRST = 2'h1,
		RB_SECOND = 2'h2
	} readback_state_t;

	// Word leaving the matcher toward the array side
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} word_beat_t;
endpackage : bus_match_pkg

`default_nettype wire

// [verification/array_model.sv]
// Purpose: Array side of the matcher, read words and write sink
// Assumes: Stall held by the bench
// Notes: Read word halves and lanes all differ
`default_nettype none

module array_model
	import bus_match_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire word_beat_t i_beat,
	output logic [WORD_W-1:0] o_rdata,
	output logic o_ready,
	output word_beat_t o_last,
	output int o_taken
);
	// Word pattern from address
	assign o_rdata = {6'h2a, i_addr, ~i_addr};
	assign o_ready = !i_stall;

	// Record each word taken
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_taken <= 0;
		end else if (i_valid && o_ready) begin
			o_last <= i_beat;
			o_taken <= o_taken + 1;
		end
	end
endmodule : array_model

`default_nettype wire

// [verification/bus_match_assertions.sv]
// Purpose: Port checks for the width matcher
// Assumes: Configuration static while in use
// Notes: Bound from tb_top
`default_nettype none

module bus_match_assertions
	import bus_match_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_width_match_select,
	input wire logic i_size_select,
	input wire logic i_endian_order_select,
	input wire logic i_address_load_strobe_n,
	input wire logic i_count_advance_n,
	input wire logic i_counter_clear_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_chip_enable_n,
	input wire logic i_write_n,
	input wire logic i_output_enable_n,
	input wire logic [WORD_W-1:0] i_array_rdata,
	input wire logic [WORD_W-1:0] o_data,
	input wire logic [WORD_W-1:0] o_data_oe,
	input wire logic o_wr_valid,
	input wire logic o_accept_ready,
	input wire logic [ADDR_W-1:0] o_word_addr,
	input wire logic [SUB_W-1:0] o_lane_index
);
	// ****
	// Decoded strobes
	// ****
	wire n9 = i_width_match_select && i_size_select;
	wire n18 = i_width_match_select && !i_size_select;
	wire ld = i_counter_clear_n && !i_address_load_strobe_n
		&& !i_count_advance_n;
	wire inc = i_counter_clear_n && i_address_load_strobe_n
		&& !i_count_advance_n;
	wire rd = !i_chip_enable_n && i_write_n && !i_output_enable_n;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	a_clear_zero: assert property (
		!i_counter_clear_n |=> o_word_addr == 15'h0) else $error("no clear");
	a_load_addr: assert property (
		ld |=> o_word_addr == $past(i_addr)) else $error("bad load");
	a_hold_still: assert property (
		i_counter_clear_n && i_count_advance_n
		|=> $stable(o_word_addr) && $stable(o_lane_index))
		else $error("hold moved");
	a_inc_word: assert property (
		inc && !i_width_match_select
		|=> o_word_addr == $past(o_word_addr) + 15'h1) else $error("no inc");
	a_lane_up: assert property (
		inc && n9 && !i_endian_order_select
		|=> o_lane_index == $past(o_lane_index) + 2'h1) else $error("lane up");
	a_lane_down: assert property (
		inc && n9 && i_endian_order_select
		|=> o_lane_index == $past(o_lane_index) - 2'h1) else $error("lane dn");
	a_float_nine: assert property (
		$past(n9) && n9 |-> o_data_oe[35:9] == 27'h0) else $error("x9 drive");
	a_float_half: assert property (
		$past(n18) && n18 |-> o_data_oe[35:18] == 18'h0) else $error("x18 drive");
	a_read_full: assert property (
		rd && !i_width_match_select && i_address_load_strobe_n
		|=> o_data == $past(i_array_rdata) && &o_data_oe) else $error("x36 rd");
	a_push_word: assert property (
		!i_width_match_select && !i_chip_enable_n && !i_write_n
		&& o_accept_ready |=> o_wr_valid) else $error("no push");

	// Main scenarios
	cover property (ld && n9);
	cover property (inc && n9 && i_endian_order_select);
	cover property (!o_accept_ready);
endmodule : bus_match_assertions

`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench of the width matcher
// Assumes: Inputs change on the falling edge
// Notes: Array side is array_model
`default_nettype none

module tb_top;
	import bus_match_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 0, rst_n = 0, wm = 0, sz = 0, be = 0, stall = 0;
	logic ld_n = 1, adv_n = 1, clr_n = 1, ce_n = 1, we_n = 1, oe_n = 1;
	logic [14:0] addr = 15'h0, waddr;
	logic [35:0] din = 36'h0, dout, doe, rdata;
	logic [1:0] lane;
	logic wv, wr_rdy, acc;
	word_beat_t beat, last;
	int taken, error_cnt = 0, samples_checked = 0, cyc = 0;

	bus_match_counter dut_u (.i_ref_clk(clk), .i_reset_n(rst_n),
		.i_width_match_select(wm), .i_size_select(sz),
		.i_endian_order_select(be), .i_address_load_strobe_n(ld_n),
		.i_count_advance_n(adv_n), .i_counter_clear_n(clr_n),
		.i_addr(addr), .i_chip_enable_n(ce_n), .i_write_n(we_n),
		.i_output_enable_n(oe_n), .i_data(din), .o_data(dout),
		.o_data_oe(doe), .i_array_rdata(rdata), .o_wr_valid(wv),
		.i_wr_ready(wr_rdy), .o_wr_beat(beat), .o_accept_ready(acc),
		.o_word_addr(waddr), .o_lane_index(lane));
	array_model array_u (.i_ref_clk(clk), .i_reset_n(rst_n),
		.i_addr(waddr), .i_stall(stall), .i_valid(wv), .i_beat(beat),
		.o_rdata(rdata), .o_ready(wr_rdy), .o_last(last), .o_taken(taken));

	// Clock and hang guard
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end

	task test_done();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk

	task tick();
		@(posedge clk);
		@(negedge clk);
	endtask : tick

	task ctl(input logic l, a, c, e, w, o);
		{ld_n, adv_n, clr_n, ce_n, we_n, oe_n} = {l, a, c, e, w, o};
	endtask : ctl

	task cfg(input logic m, s, b);
		{wm, sz, be} = {m, s, b};
		ctl(1, 1, 1, 1, 1, 1);
		tick();
	endtask : cfg

	task t_counter();
		addr = 15'h7fff;
		ctl(0, 0, 0, 1, 1, 1);
		tick();
		chk(waddr, 15'h0);
		ctl(0, 0, 1, 1, 1, 1);
		tick();
		chk(waddr, 15'h7fff);
		addr = 15'h1234;
		ctl(1, 1, 1, 1, 1, 1);
		tick();
		tick();
		chk(waddr, 15'h7fff);
		ctl(1, 0, 1, 1, 1, 1);
		tick();
		chk(waddr, 15'h0);
		tick();
		chk(waddr, 15'h1);
		ctl(1, 0, 0, 0, 1, 0);
		tick();
		chk(waddr, 15'h0);
	endtask : t_counter

	task t_read(input logic m, s, b);
		logic [35:0] w, msk;
		int n, wd, j;
		n = !m ? 1 : (s ? 4 : 2);
		wd = 36 / n;
		msk = (36'h1 << wd) - 36'h1;
		cfg(m, s, b);
		addr = 15'h1a5c;
		w = {6'h2a, addr, ~addr};
		ctl(0, 0, 1, 1, 1, 1);
		tick();
		ctl(1, 0, 1, 0, 1, 0);
		for (int k = 0; k < n; k++) begin
			tick();
			j = b ? n - 1 - k : k;
			chk(doe, msk);
			chk(dout & msk, (w >> (j * wd)) & msk);
		end
		chk(waddr, 15'h1a5d);
		if (m) chk(lane, b ? 2'h3 : 2'h0);
	endtask : t_read

	task t_readback(input logic m, s);
		cfg(m, s, 0);
		addr = 15'h2b5a;
		ctl(0, 0, 1, 1, 1, 1);
		tick();
		ctl(0, 1, 1, 0, 1, 0);
		tick();
		if (!m) chk(dout[17:3], addr);
		else if (!s) chk(dout[17:2], {addr, 1'b0});
		else chk(dout[8:0], addr[14:6]);
		tick();
		if (m && s) chk(dout[8:1], {addr[5:0], 2'h0});
		if (m && s) tick();
	endtask : t_readback

	task t_write(input logic s, b);
		logic [35:0] w;
		int n, j, t0;
		n = s ? 4 : 2;
		cfg(1, s, b);
		addr = 15'h2c3;
		w = 36'h987654321;
		t0 = taken;
		// Load alone, so the first write slice lands on the first lane
		ctl(0, 0, 1, 1, 1, 1);
		tick();
		for (int k = 0; k < n; k++) begin
			j = b ? n - 1 - k : k;
			din = w >> (j * (36 / n));
			ctl(1, 0, 1, 0, 0, 1);
			tick();
		end
		ctl(1, 1, 1, 1, 1, 1);
		for (int i = 0; i < 8 && taken == t0; i++) tick();
		chk(taken - t0, 1);
		chk(last, {15'h2c3, w});
	endtask : t_write

	task t_fill();
		int t0;
		cfg(0, 0, 0);
		stall = 1;
		t0 = taken;
		ctl(0, 0, 1, 0, 0, 1);
		for (int k = 0; k <= FIFO_DEPTH; k++) begin
			addr = 15'(k);
			din = {21'h15a5a, addr};
			tick();
		end
		ctl(1, 1, 1, 1, 1, 1);
		chk({acc, wv}, 2'h1);
		stall = 0;
		for (int i = 0; i < 20 && wv === 1'b1; i++) tick();
		chk(taken - t0, FIFO_DEPTH);
		chk(last, {15'(FIFO_DEPTH - 1), 21'h15a5a,
			15'(FIFO_DEPTH - 1)});
	endtask : t_fill

	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		chk({waddr, lane, doe}, 53'h0);
		t_counter();
		for (int i = 0; i < 6; i++) t_read(i > 1, i > 3, i[0]);
		for (int i = 0; i < 3; i++) t_readback(i > 0, i > 1);
		for (int i = 0; i < 4; i++) t_write(i > 1, i[0]);
		t_fill();
		test_done();
	end
endmodule : tb_top

bind bus_match_counter bus_match_assertions chk_u (.*);

`default_nettype wire
